// ===== remote_command_packet_interpreter.sv
`include "cmd_interp_consts.svh"
`default_nettype none
module remote_command_packet_interpreter (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rxd,
	output logic txd,
	output logic tx_enable,
	input wire logic factory_restore,
	input wire logic [7:0] addr_set,
	input wire logic addr_load,
	output logic [7:0] own_addr,
	output cmd_interp_pkg::store_req_type store_req
);
	// Local address register and parameter image
	logic [7:0] addr_reg;
	logic [7:0] params_reg [0:`PARAM_COUNT-1];
	cmd_interp_pkg::state_type s_reg;
	cmd_interp_pkg::state_type s_next;
	logic commit;
	logic [7:0] tx_byte;

	// Address held locally; factory restore gives address 1
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= `DEFAULT_ADDR;
		end else if (factory_restore) begin
			addr_reg <= `DEFAULT_ADDR;
		end else if (addr_load) begin
			addr_reg <= addr_set;
		end
	end

	// Parameter image, one entry per generate slot
	// Same gate as the store pulse: a foreign or overlapping packet leaves the image alone
	assign commit = (s_reg.phase == cmd_interp_pkg::st_check) && s_reg.rx_strobe
		&& (s_reg.rx_byte == s_reg.sum) && s_reg.cmd[`WRITE_BIT]
		&& (s_reg.dest == addr_reg)
		&& (s_reg.tx_phase == cmd_interp_pkg::tx_idle);
	genvar gi;
	generate
		for (gi = 0; gi < `PARAM_COUNT; gi++) begin : g_param
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					params_reg[gi] <= `PARAM_RESET;
				end else if (commit && s_reg.cmd[3:0] == 4'(gi)) begin
					params_reg[gi] <= s_reg.data;
				end
			end
		end
	endgenerate

	// Byte chosen by the response emitter for each phase
	always_comb begin
		case (s_reg.tx_phase)
			cmd_interp_pkg::tx_pad: tx_byte = `PAD_BYTE;
			cmd_interp_pkg::tx_open: tx_byte = `OPEN_FLAG;
			cmd_interp_pkg::tx_dest: tx_byte = s_reg.src;
			cmd_interp_pkg::tx_src: tx_byte = addr_reg;
			cmd_interp_pkg::tx_cmd: tx_byte = s_reg.cmd;
			cmd_interp_pkg::tx_data: tx_byte = s_reg.resp_data;
			cmd_interp_pkg::tx_close: tx_byte = `CLOSE_FLAG;
			cmd_interp_pkg::tx_check: tx_byte = s_reg.tx_sum;
			default: tx_byte = 8'h00;
		endcase
	end

	// Next-state logic: UART receive, packet parse, response send
	always_comb begin
		s_next = s_reg;
		s_next.rx_strobe = 1'b0;
		s_next.store_valid = 1'b0;
		s_next.rxd_prev = rxd;
		// Receiver: 8 data bits, one stop, no parity
		if (!s_reg.rx_busy) begin
			if (s_reg.rxd_prev && !rxd) begin
				s_next.rx_busy = 1'b1;
				s_next.rx_cnt = 16'((`BIT_CYCLES * 3) / 2);
				s_next.rx_bit = 4'h0;
			end
		end else if (s_reg.rx_cnt != 16'h0000) begin
			s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
		end else if (s_reg.rx_bit < 4'(`DATA_BITS)) begin
			s_next.rx_shift = {rxd, s_reg.rx_shift[7:1]};
			s_next.rx_bit = s_reg.rx_bit + 4'h1;
			s_next.rx_cnt = 16'(`BIT_CYCLES - 1);
		end else begin
			// Stop bit sample; framing error drops the byte
			s_next.rx_busy = 1'b0;
			if (rxd) begin
				s_next.rx_byte = s_reg.rx_shift;
				s_next.rx_strobe = 1'b1;
			end
		end
		// Packet parser works on received bytes
		if (s_reg.rx_strobe) begin
			case (s_reg.phase)
				cmd_interp_pkg::st_hunt: begin
					if (s_reg.rx_byte == `OPEN_FLAG) begin
						s_next.phase = cmd_interp_pkg::st_dest;
						s_next.sum = 8'h00;
					end
				end
				cmd_interp_pkg::st_dest: begin
					s_next.dest = s_reg.rx_byte;
					s_next.sum = s_reg.sum + s_reg.rx_byte;
					s_next.phase = cmd_interp_pkg::st_src;
				end
				cmd_interp_pkg::st_src: begin
					s_next.src = s_reg.rx_byte;
					s_next.sum = s_reg.sum + s_reg.rx_byte;
					s_next.phase = cmd_interp_pkg::st_cmd;
				end
				cmd_interp_pkg::st_cmd: begin
					s_next.cmd = s_reg.rx_byte;
					s_next.sum = s_reg.sum + s_reg.rx_byte;
					s_next.phase = cmd_interp_pkg::st_data;
				end
				cmd_interp_pkg::st_data: begin
					// One data byte, or the closing flag for a read
					if (s_reg.rx_byte == `CLOSE_FLAG && !s_reg.cmd[`WRITE_BIT]) begin
						s_next.phase = cmd_interp_pkg::st_check;
					end else begin
						s_next.data = s_reg.rx_byte;
						s_next.sum = s_reg.sum + s_reg.rx_byte;
						s_next.phase = cmd_interp_pkg::st_resp;
					end
				end
				cmd_interp_pkg::st_resp: begin
					// Expect closing flag after write data
					if (s_reg.rx_byte == `CLOSE_FLAG) begin
						s_next.phase = cmd_interp_pkg::st_check;
					end else begin
						s_next.phase = cmd_interp_pkg::st_hunt;
					end
				end
				cmd_interp_pkg::st_check: begin
					s_next.phase = cmd_interp_pkg::st_hunt;
					// Check word, address and an idle response emitter must all hold
					if (s_reg.rx_byte == s_reg.sum && s_reg.dest == addr_reg
						&& s_reg.tx_phase == cmd_interp_pkg::tx_idle) begin
						if (s_reg.cmd[`WRITE_BIT]) begin
							s_next.store_valid = 1'b1;
							s_next.store_index = s_reg.cmd[3:0];
							s_next.store_value = s_reg.data;
							s_next.resp_data = s_reg.data;
						end else begin
							s_next.resp_data = params_reg[s_reg.cmd[3:0]];
						end
						s_next.tx_phase = cmd_interp_pkg::tx_pad;
						s_next.tx_sum = 8'h00;
					end
				end
				default: s_next.phase = cmd_interp_pkg::st_hunt;
			endcase
		end
		// Transmitter: idle line high, only while a response is pending
		if (s_reg.tx_phase == cmd_interp_pkg::tx_idle) begin
			s_next.txd = 1'b1;
		end else if (!s_reg.tx_busy) begin
			s_next.tx_busy = 1'b1;
			s_next.tx_shift = tx_byte;
			s_next.tx_bit = 4'h0;
			s_next.tx_cnt = 16'(`BIT_CYCLES - 1);
			s_next.txd = 1'b0;
			if (s_reg.tx_phase != cmd_interp_pkg::tx_pad
				&& s_reg.tx_phase != cmd_interp_pkg::tx_open
				&& s_reg.tx_phase != cmd_interp_pkg::tx_close
				&& s_reg.tx_phase != cmd_interp_pkg::tx_check) begin
				s_next.tx_sum = s_reg.tx_sum + tx_byte;
			end
		end else if (s_reg.tx_cnt != 16'h0000) begin
			s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
		end else if (s_reg.tx_bit < 4'(`DATA_BITS)) begin
			s_next.txd = s_reg.tx_shift[0];
			s_next.tx_shift = {1'b1, s_reg.tx_shift[7:1]};
			s_next.tx_bit = s_reg.tx_bit + 4'h1;
			s_next.tx_cnt = 16'(`BIT_CYCLES - 1);
		end else if (s_reg.tx_bit == 4'(`DATA_BITS)) begin
			s_next.txd = 1'b1; // Stop bit
			s_next.tx_bit = s_reg.tx_bit + 4'h1;
			s_next.tx_cnt = 16'(`BIT_CYCLES - 1);
		end else begin
			// Byte done: move to next field
			s_next.tx_busy = 1'b0;
			case (s_reg.tx_phase)
				cmd_interp_pkg::tx_pad: s_next.tx_phase = cmd_interp_pkg::tx_open;
				cmd_interp_pkg::tx_open: s_next.tx_phase = cmd_interp_pkg::tx_dest;
				cmd_interp_pkg::tx_dest: s_next.tx_phase = cmd_interp_pkg::tx_src;
				cmd_interp_pkg::tx_src: s_next.tx_phase = cmd_interp_pkg::tx_cmd;
				cmd_interp_pkg::tx_cmd: s_next.tx_phase = cmd_interp_pkg::tx_data;
				cmd_interp_pkg::tx_data: s_next.tx_phase = cmd_interp_pkg::tx_close;
				cmd_interp_pkg::tx_close: s_next.tx_phase = cmd_interp_pkg::tx_check;
				default: s_next.tx_phase = cmd_interp_pkg::tx_idle;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
			s_reg.txd <= 1'b1;
			s_reg.rxd_prev <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign txd = s_reg.txd;
	assign tx_enable = (s_reg.tx_phase != cmd_interp_pkg::tx_idle);
	assign own_addr = addr_reg;
	assign store_req.valid = s_reg.store_valid;
	assign store_req.index = s_reg.store_index;
	assign store_req.value = s_reg.store_value;
endmodule
`default_nettype wire

// ===== cmd_interp_consts.svh
`ifndef CMD_INTERP_CONSTS_SVH
`define CMD_INTERP_CONSTS_SVH
// Framing bytes
`define PAD_BYTE 8'hff
`define OPEN_FLAG 8'ha5
`define CLOSE_FLAG 8'h96
// Factory port settings
`define DEFAULT_ADDR 8'h01
`define DEFAULT_RATE_BPS 9600
`define CLOCK_HZ 20000000
// Bit time in cycles, rounded down
`define BIT_CYCLES (`CLOCK_HZ / `DEFAULT_RATE_BPS)
`define DATA_BITS 8
// Command byte: bit 7 set means write
`define WRITE_BIT 7
`define PARAM_COUNT 16
`define PARAM_RESET 8'h00
`define MAX_DATA 4
`endif

// ===== cmd_interp_pkg.sv
`default_nettype none
package cmd_interp_pkg;
	// Receiver / interpreter phases
	typedef enum logic [3:0] {
		st_hunt, st_dest, st_src, st_cmd, st_data, st_check, st_resp
	} phase_type;
	// Response emitter phases
	typedef enum logic [3:0] {
		tx_idle, tx_pad, tx_open, tx_dest, tx_src, tx_cmd, tx_data, tx_close, tx_check
	} tx_phase_type;
	// Store-request carrier toward the nonvolatile memory
	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic [7:0] value;
	} store_req_type;
	// State of the interpreter, apart from the address register and parameter image
	typedef struct packed {
		phase_type phase;
		tx_phase_type tx_phase;
		logic [7:0] dest;
		logic [7:0] src;
		logic [7:0] cmd;
		logic [7:0] data;
		logic [7:0] sum;
		logic [7:0] tx_sum;
		logic [7:0] tx_shift;
		logic [3:0] tx_bit;
		logic [15:0] tx_cnt;
		logic tx_busy;
		logic txd;
		logic [7:0] rx_shift;
		logic [3:0] rx_bit;
		logic [15:0] rx_cnt;
		logic rx_busy;
		logic rxd_prev;
		logic [7:0] rx_byte;
		logic rx_strobe;
		logic store_valid;
		logic [3:0] store_index;
		logic [7:0] store_value;
		logic [7:0] resp_data;
	} state_type;
endpackage
`default_nettype wire

// ===== cmd_interp_fix.sv
`default_nettype none
`default_nettype wire

// ===== cmd_interp_monitor.sv
`include "cmd_interp_consts.svh"
`default_nettype none
module cmd_interp_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rxd,
	input wire logic txd,
	input wire logic tx_enable,
	input wire logic factory_restore,
	input wire logic [7:0] addr_set,
	input wire logic addr_load,
	input wire logic [7:0] own_addr,
	input wire cmd_interp_pkg::store_req_type store_req
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int gap_max = 10 * `BIT_CYCLES;
	localparam int frame_min = 79 * `BIT_CYCLES;
	int quiet_reg; // Cycles since rxd was last low
	int on_reg; // Cycles tx_enable has stood high
	// Helper counters
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			quiet_reg <= gap_max;
			on_reg <= 0;
		end else begin
			quiet_reg <= (!rxd) ? 0 : (quiet_reg < gap_max ? quiet_reg + 1 : gap_max);
			on_reg <= tx_enable ? on_reg + 1 : 0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_open; $rose(tx_enable); endsequence
	sequence s_start_bit; ##[0:1000] !txd; endsequence
	property p_idle_high; !tx_enable |-> txd; endproperty
	property p_answer_only; s_open |-> quiet_reg < gap_max; endproperty
	property p_store_pulse; store_req.valid |=> !store_req.valid; endproperty
	property p_store_resp; $rose(store_req.valid) |-> ##[0:2] tx_enable; endproperty
	property p_resp_start; s_open |-> s_start_bit; endproperty
	property p_resp_len; $fell(tx_enable) |-> on_reg >= frame_min; endproperty
	property p_store_cause; store_req.valid |-> quiet_reg < gap_max; endproperty
	property p_addr_load; addr_load && !factory_restore |-> ##[1:2] own_addr == addr_set;
	endproperty
	property p_restore; factory_restore |-> ##[1:2] own_addr == `DEFAULT_ADDR; endproperty
	a_idle_high: assert property (p_idle_high) else $error("txd low while idle");
	a_answer_only: assert property (p_answer_only) else $error("unsolicited reply");
	a_store_pulse: assert property (p_store_pulse) else $error("store too long");
	a_store_resp: assert property (p_store_resp) else $error("store without reply");
	a_resp_start: assert property (p_resp_start) else $error("reply never starts");
	a_resp_len: assert property (p_resp_len) else $error("reply too short");
	a_store_cause: assert property (p_store_cause) else $error("store without packet");
	a_addr_load: assert property (p_addr_load) else $error("address not loaded");
	a_restore: assert property (p_restore) else $error("address not restored");
endmodule
bind remote_command_packet_interpreter cmd_interp_monitor u_cmd_interp_monitor (.mclk(mclk),
	.nrst(nrst), .rxd(rxd), .txd(txd), .tx_enable(tx_enable), .factory_restore(factory_restore),
	.addr_set(addr_set), .addr_load(addr_load), .own_addr(own_addr), .store_req(store_req));
`default_nettype wire

// ===== ctl_link_model.sv
`include "cmd_interp_consts.svh"
`default_nettype none
module ctl_link_model (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd = 1'b1; // Line idles high
	// One 8N1 character, least significant bit first
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (`BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// Catch one reply character mid-bit; unknown if none comes
	task automatic get_byte(output logic [7:0] b);
		int n;
		b = 'x;
		n = 0;
		while (txd !== 1'b0 && n < 100 * `BIT_CYCLES) begin
			@(posedge mclk);
			n++;
		end
		if (n < 100 * `BIT_CYCLES) begin
			repeat (`BIT_CYCLES * 3 / 2) @(posedge mclk);
			for (int i = 0; i < 8; i++) begin
				b[i] = txd;
				repeat (`BIT_CYCLES) @(posedge mclk);
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== remote_command_packet_interpreter_test.sv
`include "cmd_interp_consts.svh"
`default_nettype none
module remote_command_packet_interpreter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, nrst, rxd, txd, tx_enable, factory_restore, addr_load;
	logic [7:0] addr_set, own_addr;
	logic [11:0] last_store; // Index and value of the latest store
	cmd_interp_pkg::store_req_type store_req;
	int errors = 0, total_checks = 0, cycles = 0, stores = 0;
	remote_command_packet_interpreter u_remote_command_packet_interpreter (.mclk(mclk),
		.nrst(nrst), .rxd(rxd), .txd(txd), .tx_enable(tx_enable),
		.factory_restore(factory_restore), .addr_set(addr_set), .addr_load(addr_load),
		.own_addr(own_addr), .store_req(store_req));
	ctl_link_model u_ctl_link_model (.mclk(mclk), .txd(txd), .rxd(rxd));
	always #25 mclk = ~mclk;
	// Store pulse log and hang guard
	always @(posedge mclk) begin
		cycles++;
		if (store_req.valid === 1'b1) begin
			stores++;
			last_store = {store_req.index, store_req.value};
		end
		if (cycles == 1200000) begin
			errors++;
			test_done();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Command frame; a nonzero spoil corrupts the check word
	task automatic send_pkt(input logic [7:0] dest, src, cmd, data, spoil);
		logic [7:0] s;
		s = dest + src + cmd + (cmd[7] ? data : 8'h00) + spoil;
		u_ctl_link_model.put_byte(`PAD_BYTE);
		u_ctl_link_model.put_byte(`OPEN_FLAG);
		u_ctl_link_model.put_byte(dest);
		u_ctl_link_model.put_byte(src);
		u_ctl_link_model.put_byte(cmd);
		if (cmd[7]) u_ctl_link_model.put_byte(data);
		u_ctl_link_model.put_byte(`CLOSE_FLAG);
		u_ctl_link_model.put_byte(s);
	endtask
	// Collect the eight reply characters and wait for the driver to let go
	task automatic expect_resp(input logic [7:0] dest, src, cmd, data);
		logic [7:0] e [8];
		logic [7:0] b;
		e = '{`PAD_BYTE, `OPEN_FLAG, dest, src, cmd, data, `CLOSE_FLAG, dest + src + cmd + data};
		for (int i = 0; i < 8; i++) begin
			u_ctl_link_model.get_byte(b);
			check("reply byte", b, e[i]);
		end
		repeat (`BIT_CYCLES) @(posedge mclk);
		check("reply ended", tx_enable, 1'b0);
	endtask
	task automatic quiet(input logic [31:0] n_store);
		logic seen;
		seen = 1'b0;
		repeat (4 * `BIT_CYCLES) begin
			@(posedge mclk);
			if (tx_enable !== 1'b0) seen = 1'b1;
		end
		check("silence", seen, 1'b0);
		check("no store", stores, n_store);
	endtask
	// Reset leaves address 1 and a silent, high line
	task automatic reset_idle();
		nrst = 1'b0;
		factory_restore = 1'b0;
		addr_load = 1'b0;
		addr_set = 8'h42;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check("own_addr", own_addr, `DEFAULT_ADDR);
		check("idle line", {tx_enable, txd}, 2'b01);
	endtask
	// Accepted write to parameter 3: echo reply and one store pulse
	task automatic write_ok();
		fork
			send_pkt(8'h01, 8'h20, 8'h83, 8'h5a, 8'h00);
			expect_resp(8'h20, 8'h01, 8'h83, 8'h5a);
		join
		check("store", {stores[3:0], last_store}, 16'h135a);
	endtask
	// Write with a spoiled check word: no reply, no store
	task automatic bad_check();
		send_pkt(8'h01, 8'h20, 8'h83, 8'h77, 8'h01);
		quiet(1);
	endtask
	// New local address, then a write to the old one is ignored
	task automatic foreign_addr();
		addr_load <= 1'b1;
		@(posedge mclk);
		addr_load <= 1'b0;
		repeat (3) @(posedge mclk);
		check("loaded addr", own_addr, 8'h42);
		send_pkt(8'h01, 8'h20, 8'h83, 8'h77, 8'h00);
		quiet(1);
	endtask
	// Read of parameter 3 at the new address: both refused writes left it alone
	task automatic read_back();
		fork
			send_pkt(8'h42, 8'h21, 8'h03, 8'h00, 8'h00);
			expect_resp(8'h21, 8'h42, 8'h03, 8'h5a);
		join
	endtask
	// Factory restore brings address 1 back
	task automatic restore_addr();
		factory_restore <= 1'b1;
		@(posedge mclk);
		factory_restore <= 1'b0;
		repeat (3) @(posedge mclk);
		check("restored addr", own_addr, `DEFAULT_ADDR);
	endtask
	// Scenarios in order; each waits for the reply to end before the next starts
	initial begin
		reset_idle();
		write_ok();
		bad_check();
		foreign_addr();
		read_back();
		restore_addr();
		test_done();
	end
endmodule
`default_nettype wire
